// >>> hdl/wrw_pkg.sv
package wrw_pkg;

  // Clock and timing.
  localparam int CLK_PERIOD_NS      = 40;
  localparam int RESET_PULSE_NS     = 500;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRESCALE_CYCLES    = 16384;
  localparam int PHASE_STEP         = 64;
  localparam int STRAP_WAIT         = 2;

  // Register map, byte addresses.
  localparam int             ADDR_W        = 12;
  localparam logic [11:0]    CTRL_OFFSET   = 12'h000;
  localparam logic [11:0]    CONFIG_OFFSET = 12'h004;

  // Control register fields.
  localparam int             CNT_W         = 7;
  localparam int             ACT_BIT       = 7;
  localparam int             TOP_BIT       = 6;
  localparam logic [7:0]     CTRL_RESET    = 8'h7F;
  localparam logic [6:0]     COUNT_RESET   = 7'h7F;
  localparam logic [6:0]     TRIP_VALUE    = 7'h40;

  // Configuration register fields.
  localparam int             CFG_TB_LSB    = 0;
  localparam int             CFG_HW_BIT    = 2;
  localparam int             CFG_HALT_BIT  = 3;
  localparam int             CFG_PULSE_BIT = 4;
  localparam logic [1:0]     TB_RESET      = 2'h0;

  typedef logic [1:0] wrw_tb_t;

  typedef enum {WRW_STRAP, WRW_RUN, WRW_PULSE} wrw_state_e;

  // Phase offset of the watchdog tick, in PHASE_STEP cycles, for each timebase selection.
  function automatic int wrw_tb_lsb(input wrw_tb_t sel);
    unique case (sel)
      2'h0: return 59;
      2'h1: return 53;
      2'h2: return 35;
      2'h3: return 54;
    endcase
  endfunction

  // Timebase period in quarter prescaler periods for each selection.
  function automatic int wrw_tb_msb(input wrw_tb_t sel);
    unique case (sel)
      2'h0: return 4;
      2'h1: return 8;
      2'h2: return 20;
      2'h3: return 49;
    endcase
  endfunction

endpackage

// >>> hdl/wrw_presc_if.sv
`timescale 1ns/100ps
interface wrw_presc_if;
  logic [1:0] timebase_select;
  logic       wdg_tick;
  logic       timebase_tick;

  modport ctrl  (output timebase_select, input wdg_tick, timebase_tick);
  modport presc (input timebase_select, output wdg_tick, timebase_tick);
endinterface

// >>> hdl/wrw_prescaler.sv
`timescale 1ns/100ps
module wrw_prescaler
  import wrw_pkg::*;
#(
  parameter int PRESCALE = PRESCALE_CYCLES
)(
  // Clock and reset.
  input  wire logic   pclk,
  input  wire logic   presetn,
  // Ticks to the watchdog.
  wrw_presc_if.presc  pif
);
  localparam int PW = $clog2(PRESCALE);

  if (PRESCALE < 8 || (1 << PW) != PRESCALE)
  begin : g_bad_prescale
    $error("PRESCALE must be a power of two of at least 8");
  end

  logic [PW-1:0] count;
  logic [5:0]    units;
  logic [1:0]    sel_q;
  logic [PW-1:0] phase;
  logic          unit_tick;

  // The counter is never cleared by refresh writes, so the first tick after a write
  // falls anywhere within one prescaler period.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= '0;
    else
      count <= count + 1'b1;
  end

  // The timebase selection moves the point in the sequence where the watchdog ticks.
  assign phase         = PW'((wrw_tb_lsb(pif.timebase_select) * PHASE_STEP) % PRESCALE);
  assign pif.wdg_tick  = (count == phase);
  assign unit_tick     = (count[PW-3:0] == '0);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sel_q <= TB_RESET;
    else
      sel_q <= pif.timebase_select;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      units <= '0;
    else if (sel_q != pif.timebase_select)
      units <= '0;
    else if (unit_tick)
      units <= (32'(units) >= wrw_tb_msb(pif.timebase_select) - 1) ? '0 : units + 1'b1;
  end

  // No tick in the cycle a new selection arrives, while the unit count is still stale.
  assign pif.timebase_tick = unit_tick && (sel_q == pif.timebase_select) &&
                             (32'(units) >= wrw_tb_msb(pif.timebase_select) - 1);

endmodule // wrw_prescaler

// >>> hdl/wrw_watchdog.sv
`timescale 1ns/100ps
module wrw_watchdog
  import wrw_pkg::*;
#(
  parameter int PRESCALE     = PRESCALE_CYCLES,
  parameter int PULSE_CYCLES = RESET_PULSE_CYCLES
)(
  // Clock and reset.
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave.
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Option straps.
  input  wire logic               opt_hw_watchdog_pin,
  input  wire logic               opt_halt_reset_pin,
  // Core halt handshake.
  input  wire logic               halt_request,
  output logic                    halt_enter,
  // Reset pin, open drain.
  output logic                    reset_pin_o,
  output logic                    reset_pin_oe_n,
  // Timebase tick for the clock controller.
  output logic                    timebase_tick
);

  if (PULSE_CYCLES < 2 || PULSE_CYCLES > 255)
  begin : g_bad_pulse
    $error("PULSE_CYCLES must lie between 2 and 255");
  end

  wrw_presc_if pif ();

  wrw_prescaler #(
    .PRESCALE (PRESCALE)
  ) u_prescaler (
    .pclk    (pclk),
    .presetn (presetn),
    .pif     (pif)
  );

  wrw_state_e  state;
  logic [6:0]  counter;
  logic        activation_bit;
  logic [1:0]  timebase_select;
  logic        opt_hw;
  logic        opt_halt;
  logic [1:0]  hw_sync1;
  logic [1:0]  hw_sync2;
  logic [1:0]  strap_cnt;
  logic [7:0]  pulse_cnt;
  logic        active;
  logic        tick;
  logic        ctrl_wr;
  logic        cfg_wr;
  logic        soft_trip;
  logic        roll_trip;
  logic        halt_trip;
  logic        trip;
  logic        pulse_done;
  logic        setup;
  logic        mapped;

  assign pif.timebase_select = timebase_select;
  assign tick                = pif.wdg_tick;
  assign timebase_tick       = pif.timebase_tick;

  // Option straps cross from the pins through two flip-flops.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hw_sync1 <= 2'h0;
      hw_sync2 <= 2'h0;
    end
    else
    begin
      hw_sync1 <= {opt_halt_reset_pin, opt_hw_watchdog_pin};
      hw_sync2 <= hw_sync1;
    end
  end

  // Straps are caught once, after the synchronisers have settled following reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      opt_hw   <= 1'b0;
      opt_halt <= 1'b0;
    end
    else if (state == WRW_STRAP && strap_cnt == 2'(STRAP_WAIT))
    begin
      opt_hw   <= hw_sync2[0];
      opt_halt <= hw_sync2[1];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      strap_cnt <= 2'h0;
    else if (state == WRW_STRAP)
      strap_cnt <= strap_cnt + 2'h1;
  end

  // Bus decode.
  assign setup   = psel && !penable;
  assign mapped  = (paddr == CTRL_OFFSET) || (paddr == CONFIG_OFFSET);
  assign ctrl_wr = psel && penable && pwrite && (paddr == CTRL_OFFSET) && state == WRW_RUN;
  assign cfg_wr  = psel && penable && pwrite && (paddr == CONFIG_OFFSET);
  assign pready  = 1'b1;

  assign active     = activation_bit || opt_hw;
  assign roll_trip  = active && tick && !ctrl_wr && counter == TRIP_VALUE;
  assign soft_trip  = ctrl_wr && (pwdata[ACT_BIT] || active) && !pwdata[TOP_BIT];
  assign halt_trip  = state == WRW_RUN && halt_request && active && opt_halt;
  assign trip       = state == WRW_RUN && (roll_trip || soft_trip || halt_trip);
  assign pulse_done = state == WRW_PULSE && 32'(pulse_cnt) == PULSE_CYCLES - 1;

  // HALT proceeds only when it does not turn into a watchdog reset.
  assign halt_enter = halt_request && state == WRW_RUN && !(active && opt_halt);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= WRW_STRAP;
    else
    begin
      unique case (state)
        WRW_STRAP: if (strap_cnt == 2'(STRAP_WAIT)) state <= WRW_RUN;
        WRW_RUN:   if (trip) state <= WRW_PULSE;
        WRW_PULSE: if (pulse_done) state <= WRW_RUN;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_cnt <= 8'h00;
    else if (state == WRW_PULSE)
      pulse_cnt <= pulse_cnt + 8'h01;
    else
      pulse_cnt <= 8'h00;
  end

  // The reset pin is pulled low only while the pulse lasts.
  assign reset_pin_o    = 1'b0;
  assign reset_pin_oe_n = (state != WRW_PULSE);

  // Counter: a write has priority over the prescaler tick.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      counter <= COUNT_RESET;
    else if (pulse_done)
      counter <= COUNT_RESET;
    else if (ctrl_wr)
      counter <= pwdata[CNT_W-1:0];
    else if (state == WRW_RUN && tick)
      counter <= counter - 7'h01;
  end

  // Activation is set-only; the watchdog's own reset cycle clears it as a device reset would.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      activation_bit <= CTRL_RESET[ACT_BIT];
    else if (pulse_done)
      activation_bit <= 1'b0;
    else if (ctrl_wr && pwdata[ACT_BIT])
      activation_bit <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timebase_select <= TB_RESET;
    else if (cfg_wr)
      timebase_select <= pwdata[CFG_TB_LSB +: 2];
  end

  // Read data and error are captured in the setup cycle and shown in the access cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      pslverr <= !mapped;
      if (paddr == CTRL_OFFSET)
        prdata <= {24'h00_0000, activation_bit, counter};
      else if (paddr == CONFIG_OFFSET)
        prdata <= {27'h000_0000, (state == WRW_PULSE), opt_halt, opt_hw, timebase_select};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // Checks.
  localparam int PULSE_LEN = PULSE_CYCLES;
  localparam int TICK_GAP  = PRESCALE - 1;

  logic [7:0]  pulse_len_q;
  logic [31:0] gap_cnt;
  logic        gap_valid;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_len_q <= 8'h00;
    else if (!reset_pin_oe_n)
      pulse_len_q <= pulse_len_q + 8'h01;
    else
      pulse_len_q <= 8'h00;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gap_cnt   <= 32'h0000_0000;
      gap_valid <= 1'b0;
    end
    else if (cfg_wr)
    begin
      gap_cnt   <= 32'h0000_0000;
      gap_valid <= 1'b0;
    end
    else if (tick)
    begin
      gap_cnt   <= 32'h0000_0000;
      gap_valid <= 1'b1;
    end
    else
      gap_cnt <= gap_cnt + 32'h0000_0001;
  end

  sequence s_roll;
    state == WRW_RUN && roll_trip;
  endsequence

  sequence s_pulse_start;
    state == WRW_PULSE && !reset_pin_oe_n;
  endsequence

  sequence s_soft_write;
    ctrl_wr && pwdata[ACT_BIT] && !pwdata[TOP_BIT];
  endsequence

  AST_TICK_PERIOD: assert property (@(posedge pclk) disable iff (!presetn)
    tick && gap_valid && !cfg_wr |-> gap_cnt == TICK_GAP)
    else $error("prescaler tick period wrong");

  AST_DECREMENT: assert property (@(posedge pclk) disable iff (!presetn)
    state == WRW_RUN && tick && !ctrl_wr && !trip |=> counter == $past(counter) - 7'h01)
    else $error("counter did not decrement on tick");

  AST_ROLL_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    s_roll |=> s_pulse_start)
    else $error("no reset after roll from 40h");

  AST_NO_RESET_INACTIVE: assert property (@(posedge pclk) disable iff (!presetn)
    state == WRW_RUN && !active && !ctrl_wr && !halt_request |=> state != WRW_PULSE)
    else $error("reset while watchdog inactive");

  AST_PULSE_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(reset_pin_oe_n) |-> pulse_len_q == 8'(PULSE_LEN))
    else $error("reset pulse width wrong");

  AST_DISABLED_AFTER: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(reset_pin_oe_n) |-> !activation_bit && counter == COUNT_RESET)
    else $error("not disabled after watchdog reset");

  AST_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    activation_bit && !pulse_done |=> activation_bit)
    else $error("activation bit cleared by software");

  AST_SOFT_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    s_soft_write |=> s_pulse_start ##1 !reset_pin_oe_n)
    else $error("software reset request ignored");

  AST_HALT_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    halt_trip |-> !halt_enter ##1 s_pulse_start)
    else $error("HALT did not produce reset");

  AST_HW_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    opt_hw && !activation_bit && state == WRW_RUN && tick && !ctrl_wr
      && counter == TRIP_VALUE |=> s_pulse_start)
    else $error("hardware mode did not reset");

  AST_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_wr && !soft_trip |=> counter == $past(pwdata[6:0])
      && (activation_bit || !$past(pwdata[7])))
    else $error("write did not load counter");

endmodule // wrw_watchdog

// >>> test/testbench.sv
`timescale 1ns/100ps
module testbench;
  import wrw_pkg::*;

  localparam int PRE   = 64;
  localparam int PULSE = 13;

  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              opt_hw;
  logic              opt_halt;
  logic              halt_request;
  logic              halt_enter;
  logic              reset_pin_o;
  logic              reset_pin_oe_n;
  logic              timebase_tick;
  int                n_mismatch;
  int                cmp_count;
  int                msb_tab [4] = '{4, 8, 20, 49};

  wrw_watchdog #(.PRESCALE(PRE), .PULSE_CYCLES(PULSE)) i_wrw_watchdog (
    .pclk                (pclk),
    .presetn             (presetn),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .prdata              (prdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .opt_hw_watchdog_pin (opt_hw),
    .opt_halt_reset_pin  (opt_halt),
    .halt_request        (halt_request),
    .halt_enter          (halt_enter),
    .reset_pin_o         (reset_pin_o),
    .reset_pin_oe_n      (reset_pin_oe_n),
    .timebase_tick       (timebase_tick)
  );

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_range(input int got, input int lo, input int hi, input string what);
    cmp_count++;
    if (got < lo || got > hi)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s took %0d not in %0d..%0d", $time, what, got, lo, hi);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task automatic apb_xfer(input logic [11:0] addr, input logic wr, input logic [31:0] wd,
                          output logic [31:0] rd, output logic err);
    int w;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && w < 50)
    begin
      @(posedge pclk);
      w++;
    end
    if (w >= 50)
      check_val(32'h0, 32'h1, "pready wait");
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic apb_write(input logic [11:0] addr, input logic [31:0] wd);
    logic [31:0] rd;
    logic        err;
    apb_xfer(addr, 1'b1, wd, rd, err);
  endtask

  task automatic apb_read(input logic [11:0] addr, output logic [31:0] rd, output logic err);
    apb_xfer(addr, 1'b0, 32'h0, rd, err);
  endtask

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
  endtask

  // Waits for the reset pulse, checks its delay and width, then lets the block settle.
  task automatic trip_check(input int lo, input int hi, input string what);
    int n;
    n = 0;
    while (reset_pin_oe_n !== 1'b0 && n <= hi)
    begin
      @(negedge pclk);
      n++;
    end
    check_range(n, lo, hi, what);
    check_val({31'h0, reset_pin_o}, 32'h0, "reset pin drive level");
    n = 0;
    while (reset_pin_oe_n === 1'b0 && n < 300)
    begin
      @(negedge pclk);
      n++;
    end
    check_range(n, PULSE, PULSE, "reset pulse width");
    repeat (8) @(posedge pclk);
  endtask

  initial
  begin
    logic [31:0] rd;
    logic        err;
    int          n;
    n_mismatch = 0;
    cmp_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    opt_hw = 1'b0;
    opt_halt = 1'b1;
    halt_request = 1'b0;
    do_reset();
    apb_read(CTRL_OFFSET, rd, err);
    check_val(rd, 32'h7F, "control after reset");
    apb_read(CONFIG_OFFSET, rd, err);
    check_val(rd, 32'h08, "config after reset");
    apb_read(12'h008, rd, err);
    check_val({31'h0, err}, 32'h1, "unmapped error");
    apb_write(CONFIG_OFFSET, 32'h1F);
    apb_read(CONFIG_OFFSET, rd, err);
    check_val(rd, 32'h0B, "config read-only bits");
    for (int tb = 0; tb < 4; tb++)
    begin
      apb_write(CONFIG_OFFSET, tb);
      @(negedge pclk);
      n = 0;
      while (timebase_tick !== 1'b1 && n < 1000)
      begin
        @(negedge pclk);
        n++;
      end
      @(negedge pclk);
      n = 1;
      while (timebase_tick !== 1'b1 && n < 1000)
      begin
        @(negedge pclk);
        n++;
      end
      check_range(n, msb_tab[tb] * PRE / 4, msb_tab[tb] * PRE / 4, "timebase period");
    end
    @(posedge pclk);
    halt_request <= 1'b1;
    @(negedge pclk);
    check_val({31'h0, halt_enter}, 32'h1, "halt while inactive");
    @(posedge pclk);
    halt_request <= 1'b0;
    apb_write(CTRL_OFFSET, 32'hC5);
    apb_read(CTRL_OFFSET, rd, err);
    check_val(rd | 32'h1, 32'hC5, "control load");
    apb_write(CTRL_OFFSET, 32'h42);
    trip_check(2 * PRE + 2, 3 * PRE + 1, "timeout after deactivation try");
    apb_read(CTRL_OFFSET, rd, err);
    check_val(rd, 32'h7F, "control after watchdog reset");
    apb_write(CTRL_OFFSET, 32'hC0);
    trip_check(2, PRE + 1, "timeout at zero steps");
    apb_write(CTRL_OFFSET, 32'h80);
    trip_check(1, 2, "software reset");
    apb_write(CTRL_OFFSET, 32'hFF);
    @(posedge pclk);
    halt_request <= 1'b1;
    @(negedge pclk);
    check_val({31'h0, halt_enter}, 32'h0, "halt blocked while active");
    @(posedge pclk);
    halt_request <= 1'b0;
    trip_check(1, 2, "halt reset");
    opt_hw <= 1'b1;
    do_reset();
    apb_read(CONFIG_OFFSET, rd, err);
    check_val(rd, 32'h0C, "hardware option config");
    apb_write(CTRL_OFFSET, 32'h41);
    trip_check(PRE + 2, 2 * PRE + 1, "hardware mode timeout");
    conclude();
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    conclude();
  end
endmodule // testbench
